// ===== core/can_tx_pkg.sv
// Register map and field layout of the transmit buffer and mask control block
package can_tx_pkg;
	localparam int NUM_TXB = 3;
	localparam int NUM_MASK = 2;
	localparam int MASK_BYTES = 3;
	localparam logic [7:0] OFF_MODULE_CONTROL = 8'h00;
	localparam logic [7:0] OFF_TX_STATUS = 8'h04;
	localparam logic [7:0] OFF_TXB_CONTROL = 8'h10;
	localparam logic [7:0] OFF_TXB_IDENT = 8'h1C;
	localparam logic [7:0] OFF_MASK = 8'h28;
	localparam logic [7:0] MASK_STRIDE = 8'h0C;
	localparam logic [7:0] OFF_MASK_SELECT = 8'h40;
	localparam logic [7:0] OFF_WINDOW = 8'h44;
	localparam int BIT_DONE = 7;
	localparam int BIT_ABT = 6;
	localparam int BIT_LARB = 5;
	localparam int BIT_ERR = 4;
	localparam int BIT_REQ = 3;
	localparam int BIT_ID_TYPE = 3;
	localparam int MODE_LSB = 5;
	localparam logic [7:0] SIDL_STORE = 8'hEB;
	localparam logic [7:0] SIDL_LEGACY = 8'hE3;
	localparam logic [7:0] MSEL_RESET = 8'h50;
	localparam logic [3:0] WIN_TX0 = 4'h8;
	typedef enum logic [1:0] {
		MODE_LEGACY = 2'b00,
		MODE_ENH_ONE = 2'b01,
		MODE_ENH_TWO = 2'b10
	} op_mode_t;
	typedef enum logic {
		SCH_IDLE = 1'b0,
		SCH_SEND = 1'b1
	} sched_state_t;
endpackage

// ===== core/tx_slot_if.sv
// Signals between the register front end and one transmit buffer slot
`timescale 1ns/1ps
`default_nettype none
interface tx_slot_if;
	logic wr_ctrl;
	logic wr_ident;
	logic [7:0] wdata;
	logic enhanced;
	logic sent_ok;
	logic lost_arb;
	logic bus_err;
	logic [7:0] ctrl;
	logic [7:0] ident;
	logic pending;
	logic [1:0] prio;
	modport slot(input wr_ctrl, wr_ident, wdata, enhanced, sent_ok, lost_arb, bus_err,
		output ctrl, ident, pending, prio);
	modport front(output wr_ctrl, wr_ident, wdata, enhanced, sent_ok, lost_arb, bus_err,
		input ctrl, ident, pending, prio);
endinterface
`default_nettype wire

// ===== core/tx_slot.sv
// One transmit buffer: control flags, priority and identifier byte
`timescale 1ns/1ps
`default_nettype none
module tx_slot (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Front end
	tx_slot_if.slot s
);
	logic done;
	logic abt;
	logic larb;
	logic err;
	logic req;
	logic [1:0] prio;
	logic [7:0] ident;
	logic set_req;
	logic drop_req;

	assign set_req = s.wr_ctrl && !req && s.wdata[can_tx_pkg::BIT_REQ];
	// Clearing a set request is an abort
	assign drop_req = s.wr_ctrl && req && !s.wdata[can_tx_pkg::BIT_REQ];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req <= 1'b0;
		end else if (set_req) begin
			req <= 1'b1;
		end else if (drop_req || s.sent_ok) begin
			req <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abt <= 1'b0;
			larb <= 1'b0;
			err <= 1'b0;
		end else if (set_req) begin
			abt <= 1'b0;
			larb <= 1'b0;
			err <= 1'b0;
		end else begin
			if (drop_req) begin
				abt <= 1'b1;
			end
			if (s.lost_arb) begin
				larb <= 1'b1;
			end
			if (s.bus_err) begin
				err <= 1'b1;
			end
		end
	end

	// A completion in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done <= 1'b0;
		end else if (s.sent_ok) begin
			done <= 1'b1;
		end else if (s.wr_ctrl && !s.wdata[can_tx_pkg::BIT_DONE]) begin
			done <= 1'b0;
		end
	end

	// Priority and identifier are frozen while a request stands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prio <= 2'h0;
			ident <= 8'h00;
		end else begin
			if (s.wr_ctrl && !req) begin
				prio <= s.wdata[1:0];
			end
			if (s.wr_ident && !req) begin
				ident <= s.wdata;
			end
		end
	end

	assign s.ctrl = {done && s.enhanced, abt, larb, err, req, 1'b0, prio};
	assign s.pending = req;
	assign s.prio = prio;
	assign s.ident = ident;

	a_req_clears_flags: assert property (@(posedge pclk) disable iff (!presetn)
		set_req |=> req && !abt && !larb && !err)
		else $error("request did not clear status flags");
	a_abort_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		drop_req |=> !req && abt)
		else $error("abort did not set aborted flag");
	a_sent_clears_req: assert property (@(posedge pclk) disable iff (!presetn)
		s.sent_ok && !set_req |=> !req && done)
		else $error("success did not clear request");
	a_ident_locked: assert property (@(posedge pclk) disable iff (!presetn)
		req && s.wr_ident |=> $stable(ident))
		else $error("identifier changed while request set");
	a_done_legacy: assert property (@(posedge pclk) disable iff (!presetn)
		!s.enhanced |-> !s.ctrl[can_tx_pkg::BIT_DONE] && !s.ctrl[2])
		else $error("done or bit 2 visible in legacy mode");
endmodule // tx_slot
`default_nettype wire

// ===== core/can_tx_buffer_and_mask_control.sv
// APB front end, transmit scheduler and acceptance mask registers
`timescale 1ns/1ps
`default_nettype none
module can_tx_buffer_and_mask_control #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Transmit engine
	output logic tx_go,
	output logic [1:0] tx_index,
	output logic [7:0] tx_ident,
	input wire logic tx_sent_ok,
	input wire logic tx_lost_arb,
	input wire logic tx_bus_err,
	// Acceptance filter side
	output logic [1:0] op_mode,
	output logic [1:0][2:0][7:0] accept_mask,
	output logic [7:0] mask_select,
	output logic any_tx_done_flag
);
	localparam int NT = can_tx_pkg::NUM_TXB;
	localparam int NM = can_tx_pkg::NUM_MASK;
	localparam int NB = can_tx_pkg::MASK_BYTES;

	if (ADDR_W < 8) begin : g_bad_addr
		$error("ADDR_W must be at least 8");
	end

	tx_slot_if slot_bus[NT]();

	logic [3:0] window_select;
	logic enhanced;
	can_tx_pkg::sched_state_t state;
	logic [7:0] off;
	logic hi_zero;
	logic acc_setup;
	logic acc_wr;
	logic hit;
	logic [7:0] rd_val;
	logic wr_mc;
	logic wr_stat;
	logic wr_msel;
	logic [NT-1:0] wr_ctrl;
	logic [NT-1:0] wr_ident;
	logic [NM-1:0][NB-1:0] wr_mask;
	logic [7:0] slot_ctrl [NT];
	logic [7:0] slot_ident [NT];
	logic [1:0] slot_prio [NT];
	logic [NT-1:0] slot_pend;
	logic [NT-1:0] ok_vec;
	logic found;
	logic [1:0] best;
	logic [1:0] best_prio;
	logic cur_pend;

	assign enhanced = (op_mode == can_tx_pkg::MODE_ENH_ONE) ||
		(op_mode == can_tx_pkg::MODE_ENH_TWO);
	assign off = paddr[7:0];
	assign hi_zero = (paddr >> 8) == '0;
	assign acc_setup = psel && penable && !pready;
	// Writes land only on the completing edge and need the low byte lane
	assign acc_wr = psel && penable && pready && pwrite && pstrb[0];

	genvar g;
	for (g = 0; g < NT; g++) begin : g_slot
		assign slot_bus[g].wr_ctrl = wr_ctrl[g];
		assign slot_bus[g].wr_ident = wr_ident[g];
		assign slot_bus[g].wdata = pwdata[7:0];
		assign slot_bus[g].enhanced = enhanced;
		assign ok_vec[g] = tx_sent_ok && (state == can_tx_pkg::SCH_SEND) &&
			(tx_index == 2'(g));
		assign slot_bus[g].sent_ok = ok_vec[g];
		assign slot_bus[g].lost_arb = tx_lost_arb && (state == can_tx_pkg::SCH_SEND) &&
			(tx_index == 2'(g));
		assign slot_bus[g].bus_err = tx_bus_err && (state == can_tx_pkg::SCH_SEND) &&
			(tx_index == 2'(g));
		assign slot_ctrl[g] = slot_bus[g].ctrl;
		assign slot_ident[g] = slot_bus[g].ident;
		assign slot_prio[g] = slot_bus[g].prio;
		assign slot_pend[g] = slot_bus[g].pending;

		tx_slot u_slot (
			.pclk(pclk),
			.presetn(presetn),
			.s(slot_bus[g].slot)
		);
	end

	// Address decode and read mux
	always_comb begin
		hit = 1'b0;
		rd_val = 8'h00;
		wr_mc = 1'b0;
		wr_stat = 1'b0;
		wr_msel = 1'b0;
		wr_ctrl = '0;
		wr_ident = '0;
		wr_mask = '0;
		if (!hi_zero || off[1:0] != 2'b00) begin
			hit = 1'b0;
		end else if (off == can_tx_pkg::OFF_MODULE_CONTROL) begin
			hit = 1'b1;
			rd_val = {1'b0, op_mode, 1'b0, window_select};
			wr_mc = acc_wr;
		end else if (off == can_tx_pkg::OFF_TX_STATUS) begin
			hit = 1'b1;
			rd_val = {7'h00, any_tx_done_flag};
			wr_stat = acc_wr;
		end else if (off == can_tx_pkg::OFF_MASK_SELECT) begin
			hit = 1'b1;
			rd_val = enhanced ? mask_select : 8'h00;
			wr_msel = acc_wr && enhanced;
		end else if (off == can_tx_pkg::OFF_WINDOW) begin
			// Receive buffer zero itself lives elsewhere; without the remap it reads zero
			hit = 1'b1;
			if (window_select == can_tx_pkg::WIN_TX0) begin
				rd_val = slot_ctrl[0];
				wr_ctrl[0] = acc_wr;
			end
		end else begin
			for (int i = 0; i < NT; i++) begin
				if (off == 8'(can_tx_pkg::OFF_TXB_CONTROL + 4 * i)) begin
					hit = 1'b1;
					rd_val = slot_ctrl[i];
					wr_ctrl[i] = acc_wr;
				end
				if (off == 8'(can_tx_pkg::OFF_TXB_IDENT + 4 * i)) begin
					hit = 1'b1;
					rd_val = slot_ident[i];
					wr_ident[i] = acc_wr;
				end
			end
			for (int n = 0; n < NM; n++) begin
				for (int k = 0; k < NB; k++) begin
					if (off == 8'(can_tx_pkg::OFF_MASK + can_tx_pkg::MASK_STRIDE * n + 4 * k)) begin
						hit = 1'b1;
						rd_val = accept_mask[n][k];
						if (k == 0) begin
							rd_val = accept_mask[n][k] & (enhanced ? can_tx_pkg::SIDL_STORE
								: can_tx_pkg::SIDL_LEGACY);
						end
						wr_mask[n][k] = acc_wr;
					end
				end
			end
		end
	end

	// APB answer: one wait state, data and error registered with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= acc_setup;
			if (acc_setup) begin
				prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
				pslverr <= !hit;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_mode <= can_tx_pkg::MODE_LEGACY;
			window_select <= 4'h0;
		end else if (wr_mc) begin
			op_mode <= pwdata[can_tx_pkg::MODE_LSB +: 2];
			window_select <= pwdata[3:0];
		end
	end

	// Shared completion flag; a completion in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			any_tx_done_flag <= 1'b0;
		end else if (enhanced && (|ok_vec)) begin
			any_tx_done_flag <= 1'b1;
		end else if (wr_stat && !pwdata[0]) begin
			any_tx_done_flag <= 1'b0;
		end
	end

	// Bit 3 of each low byte is kept even in legacy mode; reads hide it there
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accept_mask <= '0;
		end else begin
			for (int n = 0; n < NM; n++) begin
				for (int k = 0; k < NB; k++) begin
					if (wr_mask[n][k]) begin
						accept_mask[n][k] <= (k == 0) ? (pwdata[7:0] & can_tx_pkg::SIDL_STORE)
							: pwdata[7:0];
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_select <= can_tx_pkg::MSEL_RESET;
		end else if (wr_msel) begin
			mask_select <= pwdata[7:0];
		end
	end

	// Pick the pending buffer of highest level; later index wins a tie
	always_comb begin
		found = 1'b0;
		best = 2'h0;
		best_prio = 2'h0;
		for (int i = 0; i < NT; i++) begin
			if (slot_pend[i] && (!found || slot_prio[i] >= best_prio)) begin
				found = 1'b1;
				best = 2'(i);
				best_prio = slot_prio[i];
			end
		end
	end

	assign cur_pend = slot_pend[tx_index];

	// Scheduler. Lost arbitration or a bus error ends the attempt and the
	// buffer re-enters arbitration, so a higher level loaded meanwhile goes first.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= can_tx_pkg::SCH_IDLE;
			tx_go <= 1'b0;
			tx_index <= 2'h0;
			tx_ident <= 8'h00;
		end else begin
			case (state)
				can_tx_pkg::SCH_IDLE: begin
					if (found) begin
						state <= can_tx_pkg::SCH_SEND;
						tx_go <= 1'b1;
						tx_index <= best;
						tx_ident <= slot_ident[best];
					end
				end
				can_tx_pkg::SCH_SEND: begin
					if (tx_sent_ok || tx_lost_arb || tx_bus_err || !cur_pend) begin
						state <= can_tx_pkg::SCH_IDLE;
						tx_go <= 1'b0;
					end
				end
				default: begin
					state <= can_tx_pkg::SCH_IDLE;
					tx_go <= 1'b0;
				end
			endcase
		end
	end

	a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		acc_setup |=> pready ##1 !pready)
		else $error("APB answer not after exactly one wait");
	a_abort_drops_go: assert property (@(posedge pclk) disable iff (!presetn)
		state == can_tx_pkg::SCH_SEND && !cur_pend |=> !tx_go)
		else $error("transmit kept after request withdrawn");
	a_window_remap: assert property (@(posedge pclk) disable iff (!presetn)
		window_select == can_tx_pkg::WIN_TX0 && off == can_tx_pkg::OFF_WINDOW && hi_zero
		&& acc_wr && pwdata[can_tx_pkg::BIT_REQ] && !slot_pend[0] |=> slot_pend[0])
		else $error("window write did not reach buffer zero");
	a_shared_done: assert property (@(posedge pclk) disable iff (!presetn)
		enhanced && (|ok_vec) |=> any_tx_done_flag)
		else $error("shared done flag not set");
	a_msel_legacy: assert property (@(posedge pclk) disable iff (!presetn)
		!enhanced |=> $stable(mask_select))
		else $error("mask select changed in legacy mode");
	a_pick_highest: assert property (@(posedge pclk) disable iff (!presetn)
		state == can_tx_pkg::SCH_IDLE && slot_pend[0] && slot_pend[1]
		&& slot_prio[0] != slot_prio[1] && !slot_pend[2]
		|=> tx_index == ((slot_prio[0] > slot_prio[1]) ? 2'h0 : 2'h1))
		else $error("lower level chosen over higher");
	a_tie_high_index: assert property (@(posedge pclk) disable iff (!presetn)
		state == can_tx_pkg::SCH_IDLE && slot_pend[2] && slot_pend[1]
		&& slot_prio[2] == slot_prio[1] && (!slot_pend[0] || slot_prio[0] <= slot_prio[1])
		|=> tx_index == 2'h2)
		else $error("tie not resolved to highest index");
endmodule // can_tx_buffer_and_mask_control
`default_nettype wire

// ===== tb/can_engine_model.sv
// Behavioural transmit engine on the far side of the scheduler
`timescale 1ns/1ps
`default_nettype none
module can_engine_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Scheduler side
	input wire logic tx_go,
	input wire logic [1:0] outcome,
	output logic tx_sent_ok,
	output logic tx_lost_arb,
	output logic tx_bus_err
);
	logic [1:0] cnt;
	logic done;
	// Outcome 3 holds the frame on the wire until the bench picks a result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 2'h0;
			done <= 1'b0;
			tx_sent_ok <= 1'b0;
			tx_lost_arb <= 1'b0;
			tx_bus_err <= 1'b0;
		end else begin
			tx_sent_ok <= 1'b0;
			tx_lost_arb <= 1'b0;
			tx_bus_err <= 1'b0;
			if (!tx_go) begin
				cnt <= 2'h0;
				done <= 1'b0;
			end else if (!done && cnt != 2'h2) begin
				cnt <= cnt + 2'h1;
			end else if (!done && outcome != 2'h3) begin
				tx_sent_ok <= (outcome == 2'h0);
				tx_lost_arb <= (outcome == 2'h1);
				tx_bus_err <= (outcome == 2'h2);
				done <= 1'b1;
			end
		end
	end
endmodule // can_engine_model
`default_nettype wire

// ===== tb/can_tx_buffer_and_mask_control_test.sv
// Self-checking bench for the transmit buffer and mask control block
`timescale 1ns/1ps
`default_nettype none
module can_tx_buffer_and_mask_control_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr, tx_ident, mask_select;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic tx_go, ok, lost, berr, any_tx_done_flag;
	logic [1:0] tx_index, op_mode, outcome;
	logic [1:0][2:0][7:0] accept_mask;
	int error_cnt, checked, i;
	typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic e;} row_t;
	row_t rows [18];
	can_tx_buffer_and_mask_control #(.ADDR_W(8)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_go(tx_go),
		.tx_index(tx_index), .tx_ident(tx_ident), .tx_sent_ok(ok), .tx_lost_arb(lost),
		.tx_bus_err(berr), .op_mode(op_mode), .accept_mask(accept_mask),
		.mask_select(mask_select), .any_tx_done_flag(any_tx_done_flag));
	can_engine_model i_eng (.pclk(pclk), .presetn(presetn), .tx_go(tx_go), .outcome(outcome),
		.tx_sent_ok(ok), .tx_lost_arb(lost), .tx_bus_err(berr));
	always #4 pclk = ~pclk;
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			error_cnt++;
			complete_run();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
		chk("write error", {31'h0, er}, 32'h0);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), rd, {24'h000000, exp});
	endtask
	task automatic wait_go(input logic lvl);
		int n;
		for (n = 0; n < 60; n++) begin
			@(posedge pclk);
			if (tx_go === lvl) break;
		end
		if (n == 60) begin
			error_cnt++;
			complete_run();
		end
	endtask
	initial begin
		pclk = 0;
		presetn = 0;
		{psel, penable, pwrite, paddr, pwdata, outcome} = '0;
		pstrb = 4'hF;
		rows = '{'{1, 8'h34, 8'hFF, 0}, '{0, 8'h34, can_tx_pkg::SIDL_LEGACY, 0},
			'{1, 8'h40, 8'h00, 0}, '{1, 8'h00, 8'h20, 0}, '{0, 8'h00, 8'h20, 0},
			'{0, 8'h40, can_tx_pkg::MSEL_RESET, 0}, '{1, 8'h28, 8'hFF, 0},
			'{0, 8'h28, can_tx_pkg::SIDL_STORE, 0}, '{1, 8'h2C, 8'hA5, 0},
			'{0, 8'h2C, 8'hA5, 0}, '{1, 8'h3C, 8'h5A, 0}, '{0, 8'h3C, 8'h5A, 0},
			'{1, 8'h40, 8'hE4, 0}, '{0, 8'h40, 8'hE4, 0}, '{0, 8'h48, 8'h00, 1},
			'{0, 8'h02, 8'h00, 1}, '{1, 8'h14, 8'h07, 0}, '{0, 8'h14, 8'h03, 0}};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 18; i++) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk("slave error", {31'h0, er}, {31'h0, rows[i].e});
			if (!rows[i].w && !rows[i].e) chk("table read", rd, {24'h0, rows[i].d});
		end
		chk("mask port", {24'h0, accept_mask[0][1]}, 32'hA5);
		$display("test table done");
		wr(8'h1C, 8'h3C);
		wr(8'h10, 8'h08);
		wait_go(1'b1);
		chk("ident", {24'h0, tx_ident}, 32'h3C);
		chk("index", {30'h0, tx_index}, 32'h0);
		wait_go(1'b0);
		rdc(8'h10, 8'h80);
		rdc(8'h04, 8'h01);
		wr(8'h10, 8'h00);
		rdc(8'h10, 8'h00);
		wr(8'h04, 8'h00);
		// The clear lands on the edge the write completes; look one edge later
		@(posedge pclk);
		chk("done flag", {31'h0, any_tx_done_flag}, 32'h0);
		$display("test send done");
		wr(8'h00, {4'h2, can_tx_pkg::WIN_TX0});
		wr(8'h44, 8'h02);
		rdc(8'h10, 8'h02);
		wr(8'h00, 8'h20);
		rdc(8'h44, 8'h00);
		$display("test window done");
		outcome <= 2'h3;
		wr(8'h14, 8'h0B);
		wr(8'h20, 8'h77);
		wr(8'h14, 8'h09);
		rdc(8'h20, 8'h00);
		rdc(8'h14, 8'h0B);
		wr(8'h14, 8'h00);
		rdc(8'h14, 8'h43);
		chk("go after abort", {31'h0, tx_go}, 32'h0);
		$display("test abort done");
		wr(8'h18, 8'h08);
		outcome <= 2'h1;
		// The offer rises only after the write edge; wait for it before waiting for its end
		wait_go(1'b1);
		wait_go(1'b0);
		outcome <= 2'h3;
		rdc(8'h18, 8'h28);
		outcome <= 2'h2;
		wait_go(1'b0);
		outcome <= 2'h3;
		rdc(8'h18, 8'h38);
		wr(8'h18, 8'h00);
		rdc(8'h18, 8'h70);
		$display("test errors done");
		wr(8'h10, 8'h08);
		wr(8'h14, 8'h0A);
		wr(8'h18, 8'h0A);
		rdc(8'h18, 8'h0A);
		outcome <= 2'h1;
		wait_go(1'b0);
		outcome <= 2'h0;
		wait_go(1'b1);
		chk("first", {30'h0, tx_index}, 32'h2);
		wait_go(1'b0);
		wait_go(1'b1);
		chk("second", {30'h0, tx_index}, 32'h1);
		wait_go(1'b0);
		wait_go(1'b1);
		chk("third", {30'h0, tx_index}, 32'h0);
		$display("test priority done");
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		chk("reset select", {24'h0, mask_select}, 32'h50);
		chk("reset mode", {29'h0, op_mode, tx_go}, 32'h0);
		presetn <= 1'b1;
		rdc(8'h14, 8'h00);
		wr(8'h00, 8'h40);
		rdc(8'h40, can_tx_pkg::MSEL_RESET);
		wr(8'h3C, 8'h5A);
		// A write without the low byte lane must leave the register alone
		pstrb <= 4'hE;
		wr(8'h3C, 8'h11);
		pstrb <= 4'hF;
		rdc(8'h3C, 8'h5A);
		$display("test reset done");
		complete_run();
	end
endmodule // can_tx_buffer_and_mask_control_test
`default_nettype wire
